/* hdl/ivp_consts.svh */
// constants for the interrupt vector and priority logic
`ifndef IVP_CONSTS_SVH
`define IVP_CONSTS_SVH

`define IVP_NSRC 15
`define IVP_IDX_W 4
`define IVP_VEC_W 16
`define IVP_RESET_VEC 16'h0000
`define IVP_VEC_BASE 16'h0003
`define IVP_VEC_STEP 16'h0008
`define IVP_HWCLR_SRCS 4'h4

// timer control flag positions
`define IVP_TC_EXT0 1
`define IVP_TC_EXT1 3
`define IVP_TC_TMR0 5
`define IVP_TC_TMR1 7

// flag positions in the peripheral control registers
`define IVP_SER_RX 0
`define IVP_SER_TX 1
`define IVP_HI_OVF 7
`define IVP_LO_OVF 6
`define IVP_SPI_LO 4
`define IVP_SPI_HI 7
`define IVP_SMB_EVT 0
`define IVP_ADC_WIN 3
`define IVP_ADC_DONE 5
`define IVP_CA_OVF 7
`define IVP_CA_CHAN_MASK 8'h07
`define IVP_CA_MID_OVF 6
`define IVP_CMP_FALL 4
`define IVP_CMP_RISE 5

`endif

/* hdl/ivp_pkg.sv */
// types shared by both ends of the interrupt vector link
package ivp_pkg;
  typedef logic [15:0] vec_t;
  typedef logic [3:0] src_idx_t;
  typedef logic [14:0] src_mask_t;
  typedef logic [7:0] reg8_t;
endpackage

/* hdl/ivp_if.sv */
// link between the interrupt controller and the processor core
`timescale 1ns/1ps
interface ivp_if;
  import ivp_pkg::*;
  logic req;
  vec_t vector;
  src_idx_t src;
  logic ack;
  modport ctrl (output req, output vector, output src, input ack);
  modport core (input req, input vector, input src, output ack);
endinterface

/* hdl/ivp_prio_pick.sv */
// fixed priority picker: lowest index wins
`timescale 1ns/1ps
`include "ivp_consts.svh"
module ivp_prio_pick (
  input wire ivp_pkg::src_mask_t i_active,
  output logic o_found,
  output ivp_pkg::src_idx_t o_idx
);
  import ivp_pkg::*;

  always_comb begin
    o_found = 1'b0;
    o_idx = '0;
    // scan from the top down so the lowest index is written last
    for (int i = `IVP_NSRC - 1; i >= 0; i--) begin
      if (i_active[i]) begin
        o_found = 1'b1;
        o_idx = src_idx_t'(i);
      end
    end
  end
endmodule // ivp_prio_pick

/* hdl/ivp_ctrl.sv */
// interrupt controller end: pending flags, enables, priority, vector request
`timescale 1ns/1ps
`include "ivp_consts.svh"

// Behaviour
// - reset vectors to 0x0000, always, highest
// - ext pin 0: 0x0003, pos 0, hw clear
// - timer 0: 0x000B, pos 1, hw clear
// - ext pin 1: 0x0013, pos 2, hw clear
// - timer 1: 0x001B, pos 3, hw clear
// - serial rx/tx: 0x0023, pos 4, software clears
// - timer 2 overflows: 0x002B, pos 5, software clears
// - spi four flags: 0x0033, pos 6
// - smbus event: 0x003B, pos 7
// - port match: 0x0043, pos 8, no flag
// - adc window: 0x004B, pos 9
// - adc done: 0x0053, pos 10
// - counter array flags: 0x005B, pos 11
// - comparator 0 edges: 0x0063, pos 12
// - comparator 1 edges: 0x006B, pos 13
// - timer 3 overflows: 0x0073, pos 14
module ivp_ctrl (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // link to the core
  ivp_if.ctrl link,
  // flag set events for hardware-cleared sources
  input wire logic i_ext0_event,
  input wire logic i_timer0_event,
  input wire logic i_ext1_event,
  input wire logic i_timer1_event,
  // software write-one-to-clear on the timer control flags
  input wire ivp_pkg::reg8_t i_timer_control_clr,
  // peripheral control registers holding software-cleared flags, and the port match line
  input wire ivp_pkg::reg8_t i_serial_control_reg,
  input wire ivp_pkg::reg8_t i_tmr2_control_reg,
  input wire ivp_pkg::reg8_t i_spi_port_control,
  input wire ivp_pkg::reg8_t i_smbus_port_control,
  input wire logic i_port_match,
  input wire ivp_pkg::reg8_t i_adc_control_reg,
  input wire ivp_pkg::reg8_t i_counter_array_control,
  input wire ivp_pkg::reg8_t i_counter_array_pwm_reg,
  input wire ivp_pkg::reg8_t i_comp0_control_reg,
  input wire ivp_pkg::reg8_t i_comp1_control_reg,
  input wire ivp_pkg::reg8_t i_tmr3_control_reg,
  // enable registers
  input wire ivp_pkg::reg8_t i_int_enable_reg_a,
  input wire ivp_pkg::reg8_t i_int_enable_reg_b,
  // status
  output ivp_pkg::reg8_t o_timer_control_reg,
  output ivp_pkg::src_mask_t o_pending
);
  import ivp_pkg::*;

  function automatic vec_t vec_of(input src_idx_t idx);
    vec_of = vec_t'(`IVP_VEC_BASE + `IVP_VEC_STEP * vec_t'(idx));
  endfunction

  // one event flag: an event on the clearing beat keeps it set
  function automatic logic next_flag(input logic cur, input logic set,
    input logic hw_clear, input logic sw_clear);
    next_flag = set | (cur & ~hw_clear & ~sw_clear);
  endfunction

  // the paired flags of timers and comparators raise one request
  function automatic logic either_bit(input reg8_t r, input int a, input int b);
    either_bit = r[a] | r[b];
  endfunction

  // status image of the four hardware-cleared flags, other bits read 0
  function automatic reg8_t tc_image(input logic e0, input logic t0, input logic e1,
    input logic t1);
    tc_image = '0;
    tc_image[`IVP_TC_EXT0] = e0;
    tc_image[`IVP_TC_TMR0] = t0;
    tc_image[`IVP_TC_EXT1] = e1;
    tc_image[`IVP_TC_TMR1] = t1;
  endfunction

  logic ext0_pending;
  logic ext1_pending;
  logic timer0_overflow_flag;
  logic timer1_overflow_flag;
  logic [3:0] hw_clr;
  src_mask_t pending;
  src_mask_t enabled;
  logic found;
  src_idx_t win;

  // hardware clear only for positions 0..3, on the acknowledge beat
  always_comb begin
    hw_clr = '0;
    if (link.req && link.ack && link.src < `IVP_HWCLR_SRCS) begin
      hw_clr[link.src[1:0]] = 1'b1;
    end
  end

  // set wins over either clear so no edge is lost
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ext0_pending <= 1'b0;
    end else begin
      ext0_pending <= next_flag(ext0_pending, i_ext0_event, hw_clr[0],
        i_timer_control_clr[`IVP_TC_EXT0]);
    end
  end

  // timer 0 overflow flag
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      timer0_overflow_flag <= 1'b0;
    end else begin
      timer0_overflow_flag <= next_flag(timer0_overflow_flag, i_timer0_event, hw_clr[1],
        i_timer_control_clr[`IVP_TC_TMR0]);
    end
  end

  // ext pin 1 flag
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ext1_pending <= 1'b0;
    end else begin
      ext1_pending <= next_flag(ext1_pending, i_ext1_event, hw_clr[2],
        i_timer_control_clr[`IVP_TC_EXT1]);
    end
  end

  // timer 1 overflow flag
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      timer1_overflow_flag <= 1'b0;
    end else begin
      timer1_overflow_flag <= next_flag(timer1_overflow_flag, i_timer1_event, hw_clr[3],
        i_timer_control_clr[`IVP_TC_TMR1]);
    end
  end

  // software-cleared flags are read as images; the peripherals clear them
  always_comb begin
    pending[0] = ext0_pending;
    pending[1] = timer0_overflow_flag;
    pending[2] = ext1_pending;
    pending[3] = timer1_overflow_flag;
    pending[4] = either_bit(i_serial_control_reg, `IVP_SER_RX, `IVP_SER_TX);
    pending[5] = either_bit(i_tmr2_control_reg, `IVP_HI_OVF, `IVP_LO_OVF);
    pending[6] = |i_spi_port_control[`IVP_SPI_HI:`IVP_SPI_LO];
    pending[7] = i_smbus_port_control[`IVP_SMB_EVT];
    pending[8] = i_port_match;
    pending[9] = i_adc_control_reg[`IVP_ADC_WIN];
    pending[10] = i_adc_control_reg[`IVP_ADC_DONE];
    pending[11] = i_counter_array_control[`IVP_CA_OVF] |
      (|(i_counter_array_control & `IVP_CA_CHAN_MASK)) |
      i_counter_array_pwm_reg[`IVP_CA_MID_OVF];
    pending[12] = either_bit(i_comp0_control_reg, `IVP_CMP_FALL, `IVP_CMP_RISE);
    pending[13] = either_bit(i_comp1_control_reg, `IVP_CMP_FALL, `IVP_CMP_RISE);
    pending[14] = either_bit(i_tmr3_control_reg, `IVP_HI_OVF, `IVP_LO_OVF);
  end

  // positions 0..6 use enable a bits 0..6, 7..14 use enable b bits 0..7;
  // enable a bit 7 steers no position, so it is dropped here
  always_comb begin
    enabled = pending & {i_int_enable_reg_b, i_int_enable_reg_a[6:0]};
  end

  ivp_prio_pick u_pick (
    .i_active(enabled),
    .o_found(found),
    .o_idx(win)
  );

  // request is latched and held until the core acknowledges;
  // a higher source arriving meanwhile waits for the next choice
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      link.req <= 1'b0;
      link.src <= '0;
      link.vector <= `IVP_RESET_VEC;
    end else if (!link.req) begin
      if (found) begin
        link.req <= 1'b1;
        link.src <= win;
        link.vector <= vec_of(win);
      end
    end else if (link.ack) begin
      link.req <= 1'b0;
    end
  end

  // images lag the flags by one beat; software sees them a cycle late
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_timer_control_reg <= '0;
    end else begin
      o_timer_control_reg <= tc_image(ext0_pending, timer0_overflow_flag, ext1_pending,
        timer1_overflow_flag);
    end
  end

  // raw flags regardless of enable
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pending <= '0;
    end else begin
      o_pending <= pending;
    end
  end
endmodule // ivp_ctrl

/* hdl/ivp_core_end.sv */
// processor core end: boots from the reset vector, takes interrupt vectors
`timescale 1ns/1ps
`include "ivp_consts.svh"

module ivp_core_end (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // link to the controller
  ivp_if.core link,
  // return from service routine
  input wire logic i_reti,
  // fetch redirection
  output ivp_pkg::vec_t o_fetch_addr,
  output logic o_fetch_valid,
  output logic o_in_service
);
  import ivp_pkg::*;

  typedef enum logic [1:0] {
    BOOT = 2'b00,
    IDLE = 2'b01,
    TAKE = 2'b11,
    SERVICE = 2'b10
  } core_state_t;

  core_state_t state;

  // no nesting: one routine at a time, left by i_reti
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= BOOT;
      link.ack <= 1'b0;
      o_fetch_addr <= `IVP_RESET_VEC;
      o_fetch_valid <= 1'b0;
      o_in_service <= 1'b0;
    end else begin
      o_fetch_valid <= 1'b0;
      link.ack <= 1'b0;
      case (state)
        BOOT: begin
          o_fetch_addr <= `IVP_RESET_VEC;
          o_fetch_valid <= 1'b1;
          state <= IDLE;
        end
        IDLE: begin
          if (link.req) begin
            link.ack <= 1'b1;
            o_fetch_addr <= link.vector;
            o_fetch_valid <= 1'b1;
            o_in_service <= 1'b1;
            state <= TAKE;
          end
        end
        TAKE: begin
          state <= SERVICE;
        end
        SERVICE: begin
          if (i_reti) begin
            o_in_service <= 1'b0;
            state <= IDLE;
          end
        end
        default: begin
          state <= BOOT;
        end
      endcase
    end
  end
endmodule // ivp_core_end

/* sim/ivp_props.sv */
// handshake and vector checks on the interrupt link
`timescale 1ns/1ps
module ivp_props (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // link signals
  input wire logic req,
  input wire ivp_pkg::vec_t vector,
  input wire ivp_pkg::src_idx_t src,
  input wire logic ack
);
  import ivp_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  a_vec_from_src: assert property (req |-> vector == 16'h0003 + {9'h000, src, 3'h0})
    else $error("vector does not match source");
  a_no_reset_req: assert property (req |-> vector != 16'h0000)
    else $error("reset vector requested");
  a_src_in_range: assert property (req |-> src <= 4'hE)
    else $error("source out of range");
  a_req_holds: assert property (req && !ack |=> req && $stable(vector) && $stable(src))
    else $error("request changed before ack");
  a_ack_drops_req: assert property (ack |=> !req)
    else $error("request kept after ack");
  a_ack_one_cycle: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_on_req: assert property (ack |-> req)
    else $error("ack without request");
  a_fall_after_ack: assert property ($fell(req) |-> $past(ack))
    else $error("request dropped without ack");
  c_take: cover property (ack);
  c_first: cover property (req && src == 4'h0);
  c_last: cover property (req && src == 4'hE);
endmodule // ivp_props

/* sim/tb_interrupt_vector_priority.sv */
// bench for both ends of the interrupt link
`timescale 1ns/1ps
module tb_interrupt_vector_priority;
  import ivp_pkg::*;
  logic i_ref_clk = 1'b0, i_rst_b = 1'b0, reti = 1'b0, pm = 1'b0;
  logic ev0 = 1'b0, et0 = 1'b0, ev1 = 1'b0, et1 = 1'b0, fv, ins;
  reg8_t clr = 8'h00, ser = 8'h00, t2 = 8'h00, spi = 8'h00, smb = 8'h00, adc = 8'h00;
  reg8_t ca = 8'h00, pwm = 8'h00, c0 = 8'h00, c1 = 8'h00, t3 = 8'h00, tcr;
  reg8_t ena = 8'h7F, enb = 8'hFF;
  src_mask_t pend;
  vec_t fa;
  int errors = 0, n_checks = 0, k;
  // row 15 is the counter array pwm flag, served at position 11
  localparam vec_t VT[16] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
    16'h0033, 16'h003B, 16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063, 16'h006B, 16'h0073,
    16'h005B};
  localparam logic [11:0] ROWS[26] = '{12'h001, 12'h101, 12'h201, 12'h301, 12'h401, 12'h402,
    12'h580, 12'h540, 12'h680, 12'h640, 12'h620, 12'h610, 12'h701, 12'h801, 12'h908, 12'hA20,
    12'hB80, 12'hB01, 12'hB04, 12'hF40, 12'hC10, 12'hC20, 12'hD10, 12'hD20, 12'hE80, 12'hE40};
  localparam int PR[4] = '{4, 7, 12, 14};
  ivp_if lnk();
  ivp_ctrl u_ivp_ctrl (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .link(lnk),
    .i_ext0_event(ev0), .i_timer0_event(et0), .i_ext1_event(ev1), .i_timer1_event(et1),
    .i_timer_control_clr(clr), .i_serial_control_reg(ser), .i_tmr2_control_reg(t2),
    .i_spi_port_control(spi), .i_smbus_port_control(smb), .i_port_match(pm),
    .i_adc_control_reg(adc), .i_counter_array_control(ca), .i_counter_array_pwm_reg(pwm),
    .i_comp0_control_reg(c0), .i_comp1_control_reg(c1), .i_tmr3_control_reg(t3),
    .i_int_enable_reg_a(ena), .i_int_enable_reg_b(enb), .o_timer_control_reg(tcr),
    .o_pending(pend));
  ivp_core_end u_ivp_core_end (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .link(lnk),
    .i_reti(reti), .o_fetch_addr(fa), .o_fetch_valid(fv), .o_in_service(ins));
  ivp_props u_ivp_props (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .req(lnk.req),
    .vector(lnk.vector), .src(lnk.src), .ack(lnk.ack));
  always #2 i_ref_clk = ~i_ref_clk;
  task chk(input vec_t got, input vec_t exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t vec %h exp %h", $time, got, exp);
    end
  endtask
  task chk_n(input src_mask_t got, input src_mask_t exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t mask %h exp %h", $time, got, exp);
    end
  endtask
  task drive(input int p, input reg8_t b);
    case (p)
      0: ev0 <= b[0];
      1: et0 <= b[0];
      2: ev1 <= b[0];
      3: et1 <= b[0];
      4: ser <= b;
      5: t2 <= b;
      6: spi <= b;
      7: smb <= b;
      8: pm <= b[0];
      9, 10: adc <= b;
      11: ca <= b;
      12: c0 <= b;
      13: c1 <= b;
      14: t3 <= b;
      default: pwm <= b;
    endcase
  endtask
  task wait_fv;
    k = 0;
    do begin @(posedge i_ref_clk); #1; k++; end while (fv !== 1'b1 && k < 20);
    chk_n({14'h0, fv}, 15'h0001);
  endtask
  // core sits in service here, so clearing before leaving avoids a second take
  task serve(input int p, input int q);
    k = 0;
    do begin @(posedge i_ref_clk); #1; k++; end while (lnk.req !== 1'b1 && k < 20);
    chk_n({14'h0, lnk.req}, 15'h0001);
    chk(lnk.vector, VT[p]);
    chk_n(src_mask_t'(lnk.src), src_mask_t'(q));
    @(posedge i_ref_clk);
    drive(p, 8'h00);
    reti <= 1'b1;
    @(posedge i_ref_clk);
    reti <= 1'b0;
    #1 chk_n({14'h0, ins}, 15'h0000);
    wait_fv;
    chk(fa, VT[p]);
    chk_n({14'h0, ins}, 15'h0001);
  endtask
  task test_done;
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #40000;
    errors++;
    test_done;
  end
  initial begin
    repeat (20) @(posedge i_ref_clk);
    chk_n(pend, 15'h0000);
    i_rst_b <= 1'b1;
    @(posedge i_ref_clk);
    #1;
    chk(fa, 16'h0000);
    chk_n({14'h0, fv}, 15'h0001);
    @(posedge i_ref_clk);
    drive(0, 8'h01);
    wait_fv;
    chk(fa, 16'h0003);
    for (int r = 0; r < 26; r++) begin
      @(posedge i_ref_clk);
      drive(ROWS[r][11:8], ROWS[r][7:0]);
      serve(ROWS[r][11:8], ROWS[r][11:8] == 4'hF ? 11 : int'(ROWS[r][11:8]));
      repeat (3) @(posedge i_ref_clk);
      #1 chk_n(pend, 15'h0000);
    end
    @(posedge i_ref_clk);
    foreach (PR[i]) drive(PR[i], 8'hFF);
    foreach (PR[i]) serve(PR[i], PR[i]);
    @(posedge i_ref_clk);
    ena <= 8'h6E;
    drive(0, 8'h01);
    drive(4, 8'h01);
    @(posedge i_ref_clk);
    drive(0, 8'h00);
    repeat (5) @(posedge i_ref_clk);
    #1 chk_n(pend, 15'h0011);
    chk_n({14'h0, lnk.req}, 15'h0000);
    chk({8'h00, tcr}, 16'h0002);
    @(posedge i_ref_clk);
    clr <= 8'h02;
    @(posedge i_ref_clk);
    clr <= 8'h00;
    repeat (3) @(posedge i_ref_clk);
    #1 chk({8'h00, tcr}, 16'h0000);
    @(posedge i_ref_clk);
    ena <= 8'h7F;
    serve(4, 4);
    // second reset with a request standing and the core in service
    @(posedge i_ref_clk);
    drive(1, 8'h01);
    @(posedge i_ref_clk);
    drive(1, 8'h00);
    repeat (2) @(posedge i_ref_clk);
    #1 chk_n({14'h0, lnk.req}, 15'h0001);
    @(posedge i_ref_clk);
    i_rst_b <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    #1 chk_n({lnk.src, 9'h000, lnk.req, ins}, 15'h0000);
    chk(lnk.vector, 16'h0000);
    chk_n(pend, 15'h0000);
    chk({8'h00, tcr}, 16'h0000);
    @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    @(posedge i_ref_clk);
    #1 chk(fa, 16'h0000);
    chk_n({14'h0, fv}, 15'h0001);
    @(posedge i_ref_clk);
    drive(1, 8'h01);
    wait_fv;
    chk(fa, 16'h000B);
    @(posedge i_ref_clk);
    drive(1, 8'h00);
    test_done;
  end
endmodule // tb_interrupt_vector_priority
